// *** src/cbcr_consts.vh ***
// constants for the clock buffer configuration bank
`ifndef CBCR_CONSTS_VH
`define CBCR_CONSTS_VH

// byte locations
`define CBCR_LOC_OE        8'h00
`define CBCR_LOC_MODE      8'h01
`define CBCR_LOC_SLEW      8'h02
`define CBCR_LOC_FREQ      8'h03
`define CBCR_LOC_RSVD4     8'h04
`define CBCR_LOC_REV       8'h05
`define CBCR_LOC_DEVTYPE   8'h06
`define CBCR_LOC_STOP      8'h0b
`define CBCR_MAP_END       8'h0c

// field positions
`define CBCR_MODE_LATCH_HI 7
`define CBCR_MODE_LATCH_LO 6
`define CBCR_MODE_SOFT     5
`define CBCR_MODE_WR_HI    4
`define CBCR_MODE_WR_LO    3
`define CBCR_AMP_HI        1
`define CBCR_AMP_LO        0
`define CBCR_FREQ_EN       5
`define CBCR_FREQ_SEL_HI   4
`define CBCR_FREQ_SEL_LO   3
`define CBCR_FREQ_FB_FAST  0
`define CBCR_STOP_HI       1
`define CBCR_STOP_LO       0

// reset values
`define CBCR_RST_OE        8'hff
`define CBCR_RST_SLEW      8'hff
`define CBCR_RST_AMP       2'h2
`define CBCR_RST_STOP      2'h0
`define CBCR_RSVD_BYTE     8'hff
`define CBCR_STOP_RSVD_HI  2'h2

// disable states of the stop-control field
`define CBCR_STOP_LOW_LOW  2'h0
`define CBCR_STOP_HIZ      2'h1
`define CBCR_STOP_HIGH_LOW 2'h2
`define CBCR_STOP_LOW_HIGH 2'h3

// bus address and timing
`define CBCR_ADDR_UPPER    4'hd
`define CBCR_STRAP_WAIT    2'h3

`endif

// *** src/cbcr_config_regs.v ***
// smbus slave and configuration register bank of the clock buffer
`timescale 1ns/10ps
`include "cbcr_consts.vh"

// How it works
// [R1] zero enable bit forces output disable state
// [R2] mode readback bits latched from bandwidth strap
// [R3] soft source bit picks written mode bits
// [R4] amplitude field selects swing, powers up 10
// [R5] slew bits choose fast edges, reset ones
// [R6] bit five enables software frequency selection
// [R7] frequency select ignored unless enable set
// [R8] bit zero sets feedback edge rate
// [R9] location five holds fixed revision, vendor
// [R10] location six holds type and part number
// [R11] reserved bits read ones, except location 0x0b bits 7:2 (100000) and locations 7-10 (zero), writes ignored
// [R12] read-only field writes ignored, others kept
// [R13] slave-only block read and write
// [R14] stop after any byte keeps written bytes
// [R15] stop field sets true/complement disable state
module cbcr_config_regs #(
    parameter [3:0] REVISION_CODE = 4'h1,  // arbitrary value
    parameter [3:0] VENDOR_CODE   = 4'h5,  // arbitrary value
    parameter [1:0] PART_TYPE     = 2'h1,  // zero delay buffer
    parameter [5:0] PART_NUMBER   = 6'h15  // arbitrary value
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       resetn,
    // smbus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    // straps and output enable pins
    input  wire [2:0] bus_address_strap,
    input  wire [1:0] loop_bandwidth_strap,
    input  wire [7:0] out_enable_pin_n,
    // per-output run and edge rate, shared disable state
    output reg  [7:0] out_run,
    output reg  [7:0] out_edge_rate_fast,
    output reg        disable_true_level,
    output reg        disable_comp_level,
    output reg        disable_drive,
    // pll and frequency controls
    output reg  [1:0] pll_mode_active,
    output reg  [1:0] amplitude_sel,
    output reg        freq_soft_enable,
    output reg  [1:0] frequency_choice,
    output reg        feedback_edge_rate_fast
);
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_LOC  = 7'h04;
    localparam [6:0] ST_CNT  = 7'h08;
    localparam [6:0] ST_WDAT = 7'h10;
    localparam [6:0] ST_RCNT = 7'h20;
    localparam [6:0] ST_RDAT = 7'h40;

    // synchronisers: first stage is read only by the second
    reg  [9:0] pin_meta_reg;
    reg  [9:0] pin_sync_reg;
    reg  [1:0] line_last_reg;
    reg  [1:0] bw_meta_reg;
    reg  [1:0] bw_sync_reg;
    reg  [2:0] ad_meta_reg;
    reg  [2:0] ad_sync_reg;
    reg  [1:0] strap_wait_reg;
    reg  [2:0] addr_lo_reg;

    // register bank
    reg  [7:0] oe_ctrl_reg;
    reg  [1:0] mode_latched_reg;
    reg        mode_soft_reg;
    reg  [1:0] mode_write_reg;
    reg  [1:0] amp_reg;
    reg  [7:0] slew_reg;
    reg        freq_en_reg;
    reg  [1:0] freq_sel_reg;
    reg        fb_fast_reg;
    reg  [1:0] stop_reg;

    // protocol engine
    reg  [6:0] state_reg;
    reg  [6:0] state_after_reg;
    reg  [3:0] bit_cnt_reg;
    reg  [7:0] shift_reg;
    reg  [7:0] tx_reg;
    reg  [7:0] ptr_reg;
    reg  [7:0] remain_reg;
    reg        ack_ok_reg;
    reg        master_ack_reg;
    reg  [7:0] rd_data;
    reg  [7:0] rd_count;

    wire scl_s   = pin_sync_reg[0];
    wire sda_s   = pin_sync_reg[1];
    wire scl_up  = scl_s & ~line_last_reg[0];
    wire scl_dn  = ~scl_s & line_last_reg[0];
    wire start_c = scl_s & line_last_reg[0] & ~sda_s & line_last_reg[1];
    wire stop_c  = scl_s & line_last_reg[0] & sda_s & ~line_last_reg[1];
    wire xmit    = (state_reg == ST_RCNT) || (state_reg == ST_RDAT);

    // read data of the addressed location
    always @* begin
        rd_data  = 8'h00;
        rd_count = 8'h00;
        if (ptr_reg < `CBCR_MAP_END) begin
            rd_count = `CBCR_MAP_END - ptr_reg;
        end
        case (ptr_reg)
            `CBCR_LOC_OE:      rd_data = oe_ctrl_reg;
            // [R2] readback shows strap
            `CBCR_LOC_MODE:    rd_data = {mode_latched_reg, mode_soft_reg,
                                          mode_write_reg, 1'b1, amp_reg};
            `CBCR_LOC_SLEW:    rd_data = slew_reg;
            `CBCR_LOC_FREQ:    rd_data = {2'h3, freq_en_reg, freq_sel_reg,
                                          2'h3, fb_fast_reg};
            // [R11] reserved location reads ones
            `CBCR_LOC_RSVD4:   rd_data = `CBCR_RSVD_BYTE;
            // [R9] fixed identification
            `CBCR_LOC_REV:     rd_data = {REVISION_CODE, VENDOR_CODE};
            // [R10] fixed type and part
            `CBCR_LOC_DEVTYPE: rd_data = {PART_TYPE, PART_NUMBER};
            `CBCR_LOC_STOP:    rd_data = {`CBCR_STOP_RSVD_HI, 4'h0,
                                          stop_reg};
            default:           rd_data = 8'h00;
        endcase
    end

    // pin synchronisers and strap capture after reset release
    always @(posedge core_clk) begin
        pin_meta_reg  <= {out_enable_pin_n, sda_in, scl_in};
        pin_sync_reg  <= pin_meta_reg;
        line_last_reg <= pin_sync_reg[1:0];
        bw_meta_reg   <= loop_bandwidth_strap;
        bw_sync_reg   <= bw_meta_reg;
        ad_meta_reg   <= bus_address_strap;
        ad_sync_reg   <= ad_meta_reg;
        if (!resetn) begin
            strap_wait_reg   <= 2'h0;
            mode_latched_reg <= 2'h0;
            addr_lo_reg      <= 3'h0;
        end else if (strap_wait_reg != `CBCR_STRAP_WAIT) begin
            strap_wait_reg <= strap_wait_reg + 2'h1;
            if (strap_wait_reg == `CBCR_STRAP_WAIT - 2'h1) begin
                // [R2] latch bandwidth strap once
                mode_latched_reg <= bw_sync_reg;
                addr_lo_reg      <= ad_sync_reg;
            end
        end
    end

    // smbus slave engine and register writes
    always @(posedge core_clk) begin
        if (!resetn) begin
            state_reg       <= ST_IDLE;
            state_after_reg <= ST_IDLE;
            bit_cnt_reg     <= 4'h0;
            shift_reg       <= 8'h00;
            tx_reg          <= 8'h00;
            ptr_reg         <= 8'h00;
            remain_reg      <= 8'h00;
            ack_ok_reg      <= 1'b0;
            master_ack_reg  <= 1'b0;
            sda_out         <= 1'b0;
            sda_oe          <= 1'b0;
            oe_ctrl_reg     <= `CBCR_RST_OE;
            mode_soft_reg   <= 1'b0;
            mode_write_reg  <= 2'h0;
            amp_reg         <= `CBCR_RST_AMP;
            slew_reg        <= `CBCR_RST_SLEW;
            freq_en_reg     <= 1'b0;
            freq_sel_reg    <= 2'h0;
            fb_fast_reg     <= 1'b1;
            stop_reg        <= `CBCR_RST_STOP;
        end else if (start_c) begin
            // repeated start keeps the location pointer
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe      <= 1'b0;
        end else if (stop_c) begin
            // [R14] bytes already written stay committed
            state_reg <= ST_IDLE;
            sda_oe    <= 1'b0;
        end else if (state_reg != ST_IDLE) begin
            if (scl_up) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg < 4'h8) begin
                    shift_reg <= {shift_reg[6:0], sda_s};
                end else begin
                    master_ack_reg <= ~sda_s;
                end
            end else if (scl_dn && !xmit) begin
                if (bit_cnt_reg == 4'h8) begin
                    ack_ok_reg <= 1'b1;
                    sda_oe     <= 1'b1;
                    case (state_reg)
                        ST_ADDR: begin
                            // [R13] answer only our address
                            if (shift_reg[7:1] != {`CBCR_ADDR_UPPER,
                                                   addr_lo_reg}) begin
                                ack_ok_reg <= 1'b0;
                                sda_oe     <= 1'b0;
                            end
                            state_after_reg <= shift_reg[0] ? ST_RCNT
                                                            : ST_LOC;
                        end
                        ST_LOC: begin
                            ptr_reg         <= shift_reg;
                            state_after_reg <= ST_CNT;
                        end
                        ST_CNT: begin
                            remain_reg      <= shift_reg;
                            state_after_reg <= ST_WDAT;
                        end
                        ST_WDAT: begin
                            state_after_reg <= ST_WDAT;
                            if (remain_reg == 8'h00) begin
                                ack_ok_reg <= 1'b0;
                                sda_oe     <= 1'b0;
                            end else begin
                                remain_reg <= remain_reg - 8'h01;
                                ptr_reg    <= ptr_reg + 8'h01;
                                // [R12] only writable fields change
                                case (ptr_reg)
                                    `CBCR_LOC_OE:
                                        oe_ctrl_reg <= shift_reg;
                                    `CBCR_LOC_MODE: begin
                                        mode_soft_reg  <= shift_reg[
                                            `CBCR_MODE_SOFT];
                                        mode_write_reg <= shift_reg[
                                            `CBCR_MODE_WR_HI:
                                            `CBCR_MODE_WR_LO];
                                        amp_reg <= shift_reg[
                                            `CBCR_AMP_HI:`CBCR_AMP_LO];
                                    end
                                    `CBCR_LOC_SLEW:
                                        slew_reg <= shift_reg;
                                    `CBCR_LOC_FREQ: begin
                                        freq_en_reg  <= shift_reg[
                                            `CBCR_FREQ_EN];
                                        freq_sel_reg <= shift_reg[
                                            `CBCR_FREQ_SEL_HI:
                                            `CBCR_FREQ_SEL_LO];
                                        fb_fast_reg  <= shift_reg[
                                            `CBCR_FREQ_FB_FAST];
                                    end
                                    `CBCR_LOC_STOP:
                                        stop_reg <= shift_reg[
                                            `CBCR_STOP_HI:`CBCR_STOP_LO];
                                    default:
                                        ack_ok_reg <= 1'b1;
                                endcase
                            end
                        end
                        default: state_after_reg <= ST_IDLE;
                    endcase
                end else if (bit_cnt_reg == 4'h9) begin
                    bit_cnt_reg <= 4'h0;
                    if (!ack_ok_reg) begin
                        state_reg <= ST_IDLE;
                        sda_oe    <= 1'b0;
                    end else if (state_after_reg == ST_RCNT) begin
                        // [R13] block read opens with the count
                        state_reg <= ST_RCNT;
                        tx_reg    <= rd_count;
                        sda_oe    <= ~rd_count[7];
                    end else begin
                        state_reg <= state_after_reg;
                        sda_oe    <= 1'b0;
                    end
                end
            end else if (scl_dn) begin
                if (bit_cnt_reg < 4'h8) begin
                    sda_oe <= ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
                end else if (bit_cnt_reg == 4'h8) begin
                    sda_oe <= 1'b0;
                end else begin
                    bit_cnt_reg <= 4'h0;
                    // [R13] a nack from the master ends the read
                    if (master_ack_reg) begin
                        state_reg <= ST_RDAT;
                        tx_reg    <= rd_data;
                        sda_oe    <= ~rd_data[7];
                        ptr_reg   <= ptr_reg + 8'h01;
                    end else begin
                        state_reg <= ST_IDLE;
                        sda_oe    <= 1'b0;
                    end
                end
            end
        end
    end

    // outputs toward the clock path
    always @(posedge core_clk) begin
        if (!resetn) begin
            out_run                 <= 8'h00;
            out_edge_rate_fast      <= `CBCR_RST_SLEW;
            disable_true_level      <= 1'b0;
            disable_comp_level      <= 1'b0;
            disable_drive           <= 1'b1;
            pll_mode_active         <= 2'h0;
            amplitude_sel           <= `CBCR_RST_AMP;
            freq_soft_enable        <= 1'b0;
            frequency_choice        <= 2'h0;
            feedback_edge_rate_fast <= 1'b1;
        end else begin
            // [R1] zero bit overrides the enable pin
            out_run            <= oe_ctrl_reg & ~pin_sync_reg[9:2];
            // [R5] per-output edge rate
            out_edge_rate_fast <= slew_reg;
            // [R15] disable state decode
            disable_drive      <= (stop_reg != `CBCR_STOP_HIZ);
            disable_true_level <= (stop_reg == `CBCR_STOP_HIGH_LOW);
            disable_comp_level <= (stop_reg == `CBCR_STOP_LOW_HIGH);
            // [R3] mode source select
            pll_mode_active    <= mode_soft_reg ? mode_write_reg
                                                : mode_latched_reg;
            // [R4] swing select
            amplitude_sel      <= amp_reg;
            // [R6] software frequency enable
            freq_soft_enable   <= freq_en_reg;
            // [R7] select bits gated by enable
            frequency_choice   <= freq_en_reg ? freq_sel_reg : 2'h0;
            // [R8] feedback edge rate
            feedback_edge_rate_fast <= fb_fast_reg;
        end
    end
endmodule

// *** test/cbcr_config_monitor.sv ***
// assertion checker for the configuration bank ports
`timescale 1ns/10ps
module cbcr_config_monitor (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // bus and pins
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [7:0] out_enable_pin_n,
    // controls
    input wire logic [7:0] out_run,
    input wire logic [7:0] out_edge_rate_fast,
    input wire logic       disable_true_level,
    input wire logic       disable_comp_level,
    input wire logic       disable_drive,
    input wire logic [1:0] amplitude_sel,
    input wire logic       freq_soft_enable,
    input wire logic [1:0] frequency_choice,
    input wire logic       feedback_edge_rate_fast
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_run_needs_pin: assert property (
        $stable(out_enable_pin_n) [*5] |->
        (out_run & out_enable_pin_n) == 8'h00)
        else $error("output runs with its pin released");
    a_levels_excl: assert property (
        !(disable_true_level && disable_comp_level))
        else $error("both disable levels high");
    a_freq_gated: assert property (
        !freq_soft_enable |-> frequency_choice == 2'h0)
        else $error("frequency choice used while disabled");
    a_sda_no_high: assert property (
        sda_out == 1'b0) else $error("data pin driven high");
    a_sda_steady: assert property (
        scl_in [*2] |-> $stable(sda_oe)) else $error("data moved, clock high");
    a_drive_holds: assert property (
        $rose(sda_oe) |=> sda_oe [*4]) else $error("data drive too short");
    a_oe_scl_low: assert property (
        $rose(sda_oe) |-> !scl_in) else $error("data driven with clock high");
    // controls only move from bus writes, which finish while the clock is low
    a_ctrl_quiet: assert property (
        scl_in [*6] |-> $stable({out_edge_rate_fast, amplitude_sel,
        feedback_edge_rate_fast, disable_drive, disable_true_level}))
        else $error("controls changed while bus clock idle");
    c_ack: cover property ($rose(sda_oe));
    c_freq_on: cover property (!freq_soft_enable ##1 freq_soft_enable);
    c_hiz: cover property (!disable_drive);
endmodule

// *** test/cbcr_smbus_host.sv ***
// smbus host model for block reads and writes
`timescale 1ns/10ps
module cbcr_smbus_host #(
    parameter [6:0] DEV_ADDR = 7'h6d
) (
    // clock and bus
    input  wire logic core_clk,
    input  wire logic sda_line,
    output logic      scl_drv,
    output logic      sda_drv
);
    logic [7:0] wbuf [0:15];
    logic [7:0] rbuf [0:15];
    logic       ack_n;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // twice the minimum clock phase so the synchronisers keep up
    task automatic half();
        repeat (8) @(posedge core_clk);
    endtask
    task automatic put_bit(input logic b);
        sda_drv <= b;
        half();
        scl_drv <= 1'b1;
        half();
        scl_drv <= 1'b0;
    endtask
    task automatic get_bit(output logic b);
        sda_drv <= 1'b1;
        half();
        scl_drv <= 1'b1;
        half();
        b = sda_line;
        scl_drv <= 1'b0;
    endtask
    // also serves as repeated start from a low clock
    task automatic start();
        sda_drv <= 1'b1;
        half();
        scl_drv <= 1'b1;
        half();
        sda_drv <= 1'b0;
        half();
        scl_drv <= 1'b0;
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        half();
        scl_drv <= 1'b1;
        half();
        sda_drv <= 1'b1;
        half();
    endtask
    task automatic put_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(ack_n);
    endtask
    task automatic get_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask
    // location, count, then nsend bytes; stop may cut it short
    task automatic wr(input logic [7:0] loc, input logic [7:0] cnt,
                      input int nsend);
        start();
        put_byte({DEV_ADDR, 1'b0});
        put_byte(loc);
        put_byte(cnt);
        for (int i = 0; i < nsend; i++) put_byte(wbuf[i]);
        stop();
    endtask
    // count lands in rbuf[0], data from rbuf[1]; last byte nacked
    task automatic rd(input logic [7:0] loc, int n);
        start();
        put_byte({DEV_ADDR, 1'b0});
        put_byte(loc);
        start();
        put_byte({DEV_ADDR, 1'b1});
        get_byte(rbuf[0], 1'b0);
        for (int i = 1; i <= n; i++) get_byte(rbuf[i], i == n);
        stop();
    endtask
endmodule

// *** test/tb_cbcr_config_regs.sv ***
// testbench for the clock buffer configuration bank
`timescale 1ns/10ps
module tb_cbcr_config_regs;
    logic       core_clk, resetn, scl_drv, sda_drv, sda_line, sda_out, sda_oe;
    logic [2:0] bus_address_strap;
    logic [1:0] loop_bandwidth_strap, pll_mode_active, amplitude_sel;
    logic [1:0] frequency_choice;
    logic [7:0] out_enable_pin_n, out_run, out_edge_rate_fast;
    logic       disable_true_level, disable_comp_level, disable_drive;
    logic       freq_soft_enable, feedback_edge_rate_fast;
    int         num_errors, cmp_count;
    logic [7:0] exp_rst [0:6] = '{8'hff, 8'h86, 8'hff, 8'hc7, 8'hff,
                                  8'h69, 8'hea};
    // open drain with pull-up
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
    // identification values are arbitrary
    cbcr_config_regs #(.REVISION_CODE(4'h6), .VENDOR_CODE(4'h9),
        .PART_TYPE(2'h3), .PART_NUMBER(6'h2a)) dut_u (
        .core_clk(core_clk), .resetn(resetn), .scl_in(scl_drv),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .bus_address_strap(bus_address_strap),
        .loop_bandwidth_strap(loop_bandwidth_strap),
        .out_enable_pin_n(out_enable_pin_n), .out_run(out_run),
        .out_edge_rate_fast(out_edge_rate_fast),
        .disable_true_level(disable_true_level),
        .disable_comp_level(disable_comp_level),
        .disable_drive(disable_drive), .pll_mode_active(pll_mode_active),
        .amplitude_sel(amplitude_sel), .freq_soft_enable(freq_soft_enable),
        .frequency_choice(frequency_choice),
        .feedback_edge_rate_fast(feedback_edge_rate_fast));
    cbcr_smbus_host #(.DEV_ADDR(7'h6d)) host_u (.core_clk(core_clk),
        .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv));
    always #25 core_clk = ~core_clk;
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t read %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_port(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t port %h want %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask
    task automatic t_reset();
        host_u.rd(8'h00, 7);
        chk_byte(host_u.rbuf[0], 8'h0c);
        for (int i = 0; i < 7; i++) begin
            chk_byte(host_u.rbuf[i+1], exp_rst[i]);
        end
        chk_port({6'h0, pll_mode_active}, 8'h02);
        chk_port({6'h0, amplitude_sel}, 8'h02);
        chk_port(out_edge_rate_fast, 8'hff);
        chk_port({5'h0, freq_soft_enable, frequency_choice}, 8'h00);
        chk_port({7'h0, feedback_edge_rate_fast}, 8'h01);
    endtask
    task automatic t_write_fields();
        host_u.wbuf[0] = 8'h3b;
        host_u.wbuf[1] = 8'h5a;
        host_u.wbuf[2] = 8'h28;
        host_u.wbuf[3] = 8'h00;
        host_u.wr(8'h01, 8'h04, 4);
        settle();
        chk_port({6'h0, pll_mode_active}, 8'h03);
        chk_port({6'h0, amplitude_sel}, 8'h03);
        chk_port(out_edge_rate_fast, 8'h5a);
        chk_port({5'h0, freq_soft_enable, frequency_choice}, 8'h05);
        chk_port({7'h0, feedback_edge_rate_fast}, 8'h00);
        host_u.rd(8'h01, 4);
        chk_byte(host_u.rbuf[0], 8'h0b);
        chk_byte(host_u.rbuf[1], 8'hbf);
        chk_byte(host_u.rbuf[3], 8'hee);
        chk_byte(host_u.rbuf[4], 8'hff);
    endtask
    task automatic t_gating();
        host_u.wbuf[0] = 8'h18;
        host_u.wbuf[1] = 8'hff;
        host_u.wbuf[2] = 8'h19;
        host_u.wr(8'h01, 8'h03, 3);
        settle();
        chk_port({6'h0, pll_mode_active}, 8'h02);
        chk_port({6'h0, amplitude_sel}, 8'h00);
        chk_port({5'h0, freq_soft_enable, frequency_choice}, 8'h00);
    endtask
    task automatic t_oe_stop();
        host_u.wbuf[0] = 8'h0f;
        host_u.wr(8'h00, 8'h01, 1);
        settle();
        chk_port(out_run, 8'h0f);
        out_enable_pin_n <= 8'h01;
        settle();
        chk_port(out_run, 8'h0e);
        for (int c = 0; c < 4; c++) begin
            host_u.wbuf[0] = 8'(c);
            host_u.wr(8'h0b, 8'h01, 1);
            settle();
            chk_port({7'h0, disable_drive}, {7'h0, c != 1});
            if (c != 1) begin
                chk_port({6'h0, disable_true_level, disable_comp_level},
                         {6'h0, c == 2, c == 3});
            end
        end
    endtask
    task automatic t_stop_and_ro();
        host_u.wbuf[0] = 8'h33;
        host_u.wbuf[1] = 8'h00;
        host_u.wr(8'h02, 8'h03, 1);
        host_u.rd(8'h02, 2);
        chk_byte(host_u.rbuf[1], 8'h33);
        chk_byte(host_u.rbuf[2], 8'hdf);
        host_u.wr(8'h05, 8'h02, 2);
        host_u.rd(8'h05, 2);
        chk_byte(host_u.rbuf[0], 8'h07);
        chk_byte(host_u.rbuf[1], 8'h69);
        chk_byte(host_u.rbuf[2], 8'hea);
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        bus_address_strap = 3'h5;
        loop_bandwidth_strap = 2'h2;
        out_enable_pin_n = 8'h00;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge core_clk);
        t_reset();
        t_write_fields();
        t_gating();
        t_oe_stop();
        t_stop_and_ro();
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        $display("CHECK FAILED %0t run did not finish", $time);
        complete_run();
    end
endmodule
bind cbcr_config_regs cbcr_config_monitor mon_u (.core_clk(core_clk),
    .resetn(resetn), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .out_enable_pin_n(out_enable_pin_n), .out_run(out_run),
    .out_edge_rate_fast(out_edge_rate_fast),
    .disable_true_level(disable_true_level),
    .disable_comp_level(disable_comp_level), .disable_drive(disable_drive),
    .amplitude_sel(amplitude_sel), .freq_soft_enable(freq_soft_enable),
    .frequency_choice(frequency_choice),
    .feedback_edge_rate_fast(feedback_edge_rate_fast));
